// File: sps_ctl_model.sv
// controller model driving the shifter pins
`default_nettype none
module sps_ctl_model (
    input  wire logic             ref_clk_in,
    output var sps_pkg::sps_pins_t pins_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins_out = '{serial_a: 1'b0, serial_b: 1'b0, shift_clk: 1'b0, async_zero_n: 1'b1};
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask : tick
    task automatic shift(input logic a, input logic b);
        pins_out.serial_a = a;
        pins_out.serial_b = b;
        tick(1);
        pins_out.shift_clk = 1'b1;
        tick(2);
        pins_out.shift_clk = 1'b0;
        // stale data must not pass for held data
        pins_out.serial_a = ~a;
        pins_out.serial_b = ~b;
        tick(2);
    endtask : shift
    task automatic set_clear(input logic n);
        pins_out.async_zero_n = n;
        tick(4);
    endtask : set_clear
endmodule : sps_ctl_model
`default_nettype wire

// File: sps_pkg.sv
// package: constants and carrier types of the serial-in, parallel-out shifter
`default_nettype none
package sps_pkg;
    localparam int unsigned STAGES = 8;

    // pin group driven by the outside controller
    typedef struct packed {
        logic serial_a;
        logic serial_b;
        logic shift_clk;
        logic async_zero_n;
    } sps_pins_t;

    // idle clock high and clear asserted, so release of reset neither fakes an edge nor shifts
    localparam sps_pins_t PINS_RST = '{serial_a: 1'b0, serial_b: 1'b0, shift_clk: 1'b1, async_zero_n: 1'b0};
    localparam logic CLK_PREV_RST = 1'b1;
    localparam logic [STAGES-1:0] STAGES_RST = 8'h00;
    localparam logic [STAGES-1:0] STAGES_CLR = 8'h00;
    localparam int unsigned IDX_FIRST   = 0;
    localparam int unsigned IDX_SECOND  = 1;
    localparam int unsigned IDX_SEVENTH = STAGES - 2;
    localparam int unsigned IDX_LAST    = STAGES - 1;
endpackage : sps_pkg
`default_nettype wire

// File: sps_shifter.sv
// module: eight-stage serial-in, parallel-out shifter behind sampled pins
//
// Functional notes
// - eight chained stages, all visible in parallel
// - serial bit high only when both inputs high
// - either input low shifts in zero
// - of shift clock edges, only rising ones update stages
// - rising edge loads serial bit, shifts chain
// - each rising edge moves contents exactly one place
// - last stage value discarded every rising edge
// - clear low forces all stages zero, overriding
// - no edge, no clear: stages hold
`default_nettype none
module sps_shifter #(
    parameter int unsigned STAGES = sps_pkg::STAGES
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    input  wire sps_pkg::sps_pins_t pins_in,
    output logic [STAGES-1:0]      parallel_out,
    output logic                   stage_out_first_out,
    output logic                   stage_out_second_out,
    output logic                   stage_out_seventh_out,
    output logic                   stage_out_last_out
);

    // pin synchroniser and edge detect
    sps_pkg::sps_pins_t sync1_q;
    sps_pkg::sps_pins_t sync1_d;
    sps_pkg::sps_pins_t sync2_q;
    sps_pkg::sps_pins_t sync2_d;
    logic               clk_prev_q;
    logic               clk_prev_d;

    always_comb begin
        sync1_d    = pins_in;
        sync2_d    = sync1_q;
        clk_prev_d = sync2_q.shift_clk;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sync1_q    <= sps_pkg::PINS_RST;
            sync2_q    <= sps_pkg::PINS_RST;
            clk_prev_q <= sps_pkg::CLK_PREV_RST;
        end else begin
            sync1_q    <= sync1_d;
            sync2_q    <= sync2_d;
            clk_prev_q <= clk_prev_d;
        end
    end

    // shared by the chain and the pin-path check
    function automatic logic gate_serial(input sps_pkg::sps_pins_t pins);
        return pins.serial_a & pins.serial_b;
    endfunction : gate_serial

    logic rise;
    logic fall;
    logic clr_active;
    logic serial_bit;

    // the pin clock is a sampled level, not a clock domain: it must stay well below the reference rate
    assign rise       = sync2_q.shift_clk & ~clk_prev_q;
    assign fall       = ~sync2_q.shift_clk & clk_prev_q;
    assign clr_active = ~sync2_q.async_zero_n;
    assign serial_bit = gate_serial(sync2_q);

    // stage chain
    logic [STAGES-1:0] stages_q;
    logic [STAGES-1:0] stages_d;
    logic [STAGES-1:0] shifted;

    assign shifted[0] = serial_bit;

    // each stage above the first copies its lower neighbour as it stood before the edge
    for (genvar i = 1; i < STAGES; i++) begin : g_chain
        assign shifted[i] = stages_q[i-1];
    end

    always_comb begin
        if (clr_active) begin
            stages_d = sps_pkg::STAGES_CLR;
        end else if (rise) begin
            // top bit falls off the end, nothing keeps it
            stages_d = shifted;
        end else begin
            stages_d = stages_q;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            stages_q <= sps_pkg::STAGES_RST;
        end else begin
            stages_q <= stages_d;
        end
    end

    // data and clock share the same sampling delay, so pin set-up carries over
    assign parallel_out          = stages_q;
    assign stage_out_first_out   = stages_q[sps_pkg::IDX_FIRST];
    assign stage_out_second_out  = stages_q[sps_pkg::IDX_SECOND];
    assign stage_out_seventh_out = stages_q[sps_pkg::IDX_SEVENTH];
    assign stage_out_last_out    = stages_q[sps_pkg::IDX_LAST];

    // checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_shift_edge;
        rise && !clr_active;
    endsequence

    sequence s_idle;
        !rise && !clr_active;
    endsequence

    sequence s_pin_rise;
        $rose(sync1_q.shift_clk) ##1 !clr_active;
    endsequence

    sequence s_pin_fall;
        $fell(sync1_q.shift_clk) ##1 !clr_active;
    endsequence

    sequence s_clear_release;
        $rose(sync2_q.async_zero_n) && !rise;
    endsequence

    property p_pin_edge_shift;
        s_pin_rise |=> stages_q[0] == $past(serial_bit) && stages_q[STAGES-1:1] == $past(stages_q[STAGES-2:0]);
    endproperty

    property p_pin_fall_hold;
        s_pin_fall |=> $stable(stages_q);
    endproperty

    a_load_one_bit: assert property (s_shift_edge and serial_bit |=> stages_q[0])
        else $error("one did not enter first stage");

    a_load_zero_bit: assert property (s_shift_edge ##0 (!sync2_q.serial_a || !sync2_q.serial_b) |=> !stages_q[0])
        else $error("zero did not enter first stage");

    a_falling_ignored: assert property (fall && !clr_active |=> $stable(stages_q))
        else $error("stages moved on falling edge");

    a_first_stage_load: assert property (s_shift_edge |=> stages_q[0] == $past(serial_bit))
        else $error("first stage not loaded from serial bit");

    a_shift_one_place: assert property (s_shift_edge |=> stages_q[STAGES-1:1] == $past(stages_q[STAGES-2:0]))
        else $error("chain did not shift by one");

    a_last_discarded: assert property (s_shift_edge |=> stages_q == {$past(stages_q[STAGES-2:0]), $past(serial_bit)})
        else $error("last stage value retained");

    a_clear_zero: assert property (clr_active |=> stages_q == sps_pkg::STAGES_CLR)
        else $error("clear did not zero stages");

    a_clear_pin_path: assert property (!sync1_q.async_zero_n ##1 !sync2_q.async_zero_n |=> parallel_out == '0)
        else $error("clear pin did not reach outputs");

    a_hold_idle: assert property (s_idle |=> $stable(stages_q))
        else $error("stages changed without edge");

    a_outputs_together: assert property (stage_out_last_out == parallel_out[STAGES-1]
        && stage_out_first_out == parallel_out[0] && stage_out_second_out == parallel_out[1]
        && stage_out_seventh_out == parallel_out[STAGES-2])
        else $error("named outputs disagree with parallel bus");

    // pin-path checks, counted from the first or the second sampling flop
    a_gated_pin_bit: assert property (gate_serial(sync1_q) ##1 s_shift_edge |=> stages_q[0])
        else $error("gated one from pins did not reach first stage");

    a_zero_from_a: assert property (s_shift_edge ##0 !sync2_q.serial_a |=> !stages_q[0])
        else $error("low first serial input did not block a one");

    a_zero_from_b: assert property (s_shift_edge ##0 !sync2_q.serial_b |=> !stages_q[0])
        else $error("low second serial input did not block a one");

    a_rise_from_pin: assert property (rise |-> $past(sync1_q.shift_clk) && !$past(sync1_q.shift_clk, 2))
        else $error("shift edge without a low-to-high pin clock");

    a_pin_edge_shift: assert property (p_pin_edge_shift)
        else $error("pin clock rise did not shift once");

    a_pin_fall_hold: assert property (p_pin_fall_hold)
        else $error("pin clock fall moved the stages");

    a_rise_single: assert property (rise |=> !rise)
        else $error("one pin edge gave two shifts");

    a_last_lost: assert property (s_shift_edge ##0 (stages_q[STAGES-1] && !stages_q[STAGES-2])
        |=> !stages_q[STAGES-1])
        else $error("last stage value survived a shift");

    a_clear_beats_edge: assert property (rise && clr_active |=> stages_q == sps_pkg::STAGES_CLR)
        else $error("shift edge beat clear");

    a_clear_stays: assert property (clr_active ##1 clr_active |-> parallel_out == '0)
        else $error("stages not zero while clear held");

    a_clear_pin_entry: assert property ($fell(sync1_q.async_zero_n) |-> ##2 parallel_out == '0)
        else $error("clear pin fall did not zero outputs");

    a_clear_release_hold: assert property (s_clear_release |=> parallel_out == '0)
        else $error("stages moved when clear released");

    a_serial_change_idle: assert property (s_idle ##0 $changed(serial_bit) |=> $stable(stages_q))
        else $error("serial change without edge moved stages");

    // per-stage view, so a broken link names its own stage
    for (genvar j = 1; j < STAGES; j++) begin : g_stage_checks
        a_stage_follows: assert property (s_shift_edge |=> stages_q[j] == $past(stages_q[j-1]))
            else $error("stage did not take its neighbour");
        a_stage_cleared: assert property (clr_active |=> !stages_q[j])
            else $error("stage survived clear");
        a_stage_holds: assert property (s_idle |=> stages_q[j] == $past(stages_q[j]))
            else $error("stage changed without edge");
    end

endmodule : sps_shifter
`default_nettype wire

// File: sps_shifter_tb_top.sv
// self-checking bench for the shifter
`default_nettype none
module sps_shifter_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    sps_pkg::sps_pins_t pins;
    logic [7:0]         par;
    logic [3:0]         taps;
    logic [7:0]         exp_q = 8'h00;
    logic [31:0]        rng = 32'h153b8;
    int                 errors = 0;
    int                 check_count = 0;
    int                 cycles = 0;
    initial forever #25 clk = ~clk;
    sps_ctl_model sps_ctl_model_inst (.ref_clk_in(clk), .pins_out(pins));
    sps_shifter sps_shifter_inst (.ref_clk_in(clk), .rst_in(rst), .pins_in(pins), .parallel_out(par),
        .stage_out_first_out(taps[0]), .stage_out_second_out(taps[1]),
        .stage_out_seventh_out(taps[2]), .stage_out_last_out(taps[3]));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [7:0] nxt(input logic [7:0] e, input logic a, input logic b);
        return {e[6:0], a & b};
    endfunction : nxt
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic do_shift(input logic a, input logic b);
        sps_ctl_model_inst.shift(a, b);
        exp_q = nxt(exp_q, a, b);
        check("parallel", par, exp_q);
        check("taps", {4'h0, taps}, {4'h0, exp_q[7], exp_q[6], exp_q[1], exp_q[0]});
    endtask : do_shift
    // ceiling well above the ~310 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        check("reset", par, 8'h00);
        for (int i = 0; i < 4; i++) do_shift(i[0], i[1]);
        for (int i = 0; i < 9; i++) do_shift(1'b1, 1'b1);
        for (int i = 0; i < 40; i++) begin
            rng = xs(rng);
            do_shift(rng[0], rng[1]);
        end
        do_shift(1'b1, 1'b1);
        sps_ctl_model_inst.set_clear(1'b0);
        exp_q = 8'h00;
        check("cleared", par, exp_q);
        sps_ctl_model_inst.shift(1'b1, 1'b1);
        check("clear wins", par, exp_q);
        sps_ctl_model_inst.set_clear(1'b1);
        do_shift(1'b1, 1'b1);
        repeat (6) @(posedge clk);
        #1 check("hold", par, exp_q);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        exp_q = 8'h00;
        repeat (6) @(posedge clk);
        #1 check("after reset", par, exp_q);
        do_shift(1'b1, 1'b1);
        tally_and_finish();
    end
endmodule : sps_shifter_tb_top
`default_nettype wire
